// File: verilog/charger_alert_enable_logic.sv
// alert enable registers, event capture and alert output of the charger
//
// Overview of operation
// - phase enable register at 0x0E, bits 12:0, cleared at reset.
// - bit 12 alerts when detection testing cannot source battery power.
// - bit 11 alerts on entry to battery detection testing.
// - bit 10 alerts when the equalize phase begins.
// - bit 9 alerts when the absorb phase begins.
// - bit 8 alerts when charging stops on a host suspend request.
// - bit 6 alerts at onset of the constant current/voltage phase.
// - bit 1 alerts on a missing battery; charging is then prohibited.
// - bit 0 alerts on a shorted battery; charging is then prohibited.
// - loop enable register at 0x0F, bits 5:0, cleared at reset.
// - loop bit 5 alerts while the safety current limit is active.
// - loop bit 4 alerts while thermal throttling cuts charge current.
// - loop bit 3 alerts while input undervoltage regulation controls.
// - loop bit 2 alerts while input current regulation controls.
// - loop bit 1 alerts while constant current regulation controls.
// - loop bit 0 alerts while constant voltage regulation controls.
// - signed throttle start temperature at 0x10, reset 17897.
// - setpoint cap falls linearly from 31 to 0 between start and end.
// - signed throttle end temperature at 0x11, reset 18130.
`timescale 1ns/100ps
`default_nettype none
`include "charger_alert_consts.svh"
module charger_alert_enable_logic
(
  input wire logic clk_i,                             // system clock, 50 MHz
  input wire logic rst_n_i,                           // async reset, active low
  // register port, addressed by command code
  input wire logic [`CMD_W-1:0] cmd_code_i,           // command code
  input wire logic wr_stb_i,                          // write strobe, one cycle
  input wire logic [`DATA_W-1:0] wr_data_i,           // write data
  input wire logic rd_stb_i,                          // read strobe, one cycle
  output logic [`DATA_W-1:0] rd_data_o,               // read data
  output logic rd_valid_o,                            // read data valid pulse
  // charger phase indications, levels
  input wire logic detect_failed_i,                   // detection cannot source power
  input wire logic detecting_i,                       // detection testing running
  input wire logic equalize_i,                        // equalize phase
  input wire logic absorb_i,                          // absorb phase
  input wire logic suspended_i,                       // charging suspended by host
  input wire logic main_phase_i,                      // constant current/voltage phase
  input wire logic bat_missing_i,                     // no battery found
  input wire logic bat_short_i,                       // shorted battery found
  // regulation loop indications, levels
  input wire logic ilim_active_i,                     // safety current limit or dropout
  input wire logic uvcl_active_i,                     // input undervoltage loop
  input wire logic iin_limit_active_i,                // input current loop
  input wire logic cc_active_i,                       // constant current loop
  input wire logic cv_active_i,                       // constant voltage loop
  // alert handshake and thermal input
  input wire logic alert_ack_i,                       // alert response, clears pending
  input wire logic [`DATA_W-1:0] die_temp_i,          // signed die temperature
  // outputs
  output logic alert_o,                               // open-drain data, always low
  output logic alert_oe_o,                            // high while alert pulled low
  output logic [`PHASE_W-1:0] phase_pending_o,        // latched phase events
  output logic charge_prohibit_o,                     // charging prohibited
  output logic [`CAP_W-1:0] charge_cap_o,             // charge setpoint cap
  output logic throttling_o                           // thermal throttle active
);
  import charger_alert_pkg::*;

  alert_state_type s_reg;
  alert_state_type s_next;
  logic [`PHASE_W-1:0] phase_lvl;
  logic [`PHASE_W-1:0] phase_rise;
  logic [`LOOP_W-1:0] loop_lvl;
  logic [`CAP_W-1:0] ramp_cap;
  logic ramp_active;
  logic wr_phase;
  logic wr_loop;
  logic wr_begin;
  logic wr_end;

  // match a command code against one register
  function automatic logic cmd_hit(input logic [`CMD_W-1:0] code,
                                   input logic [`CMD_W-1:0] target);
    cmd_hit = (code == target);
  endfunction

  // write decode
  assign wr_phase = wr_stb_i && cmd_hit(cmd_code_i, `CMD_PHASE_EN);
  assign wr_loop = wr_stb_i && cmd_hit(cmd_code_i, `CMD_LOOP_EN);
  assign wr_begin = wr_stb_i && cmd_hit(cmd_code_i, `CMD_HEAT_BEGIN);
  assign wr_end = wr_stb_i && cmd_hit(cmd_code_i, `CMD_HEAT_END);

  // phase indications gathered at their enable bit positions;
  // unused positions stay low so they can never latch
  always_comb
  begin
    phase_lvl = '0;
    phase_lvl[`BIT_DETECT_FAIL] = detect_failed_i;
    phase_lvl[`BIT_DETECTING] = detecting_i;
    phase_lvl[`BIT_EQUALIZE] = equalize_i;
    phase_lvl[`BIT_ABSORB] = absorb_i;
    phase_lvl[`BIT_SUSPENDED] = suspended_i;
    phase_lvl[`BIT_MAIN_PHASE] = main_phase_i;
    phase_lvl[`BIT_BAT_MISSING] = bat_missing_i;
    phase_lvl[`BIT_BAT_SHORT] = bat_short_i;
  end

  // loop indications; thermal comes from the ramp, not a pin
  always_comb
  begin
    loop_lvl = '0;
    loop_lvl[`BIT_ILIM] = ilim_active_i;
    loop_lvl[`BIT_THERMAL] = ramp_active;
    loop_lvl[`BIT_UVCL] = uvcl_active_i;
    loop_lvl[`BIT_IIN_LIMIT] = iin_limit_active_i;
    loop_lvl[`BIT_CC] = cc_active_i;
    loop_lvl[`BIT_CV] = cv_active_i;
  end

  // phase alerts fire on entry into a phase, so each bit is edge detected
  // against the level seen one clock earlier
  genvar gi;
  generate
    for (gi = 0; gi < `PHASE_W; gi = gi + 1)
    begin : g_rise
      assign phase_rise[gi] = phase_lvl[gi] && !s_reg.phase_prev[gi];
    end
  endgenerate

  // thermal ramp on the two temperature registers
  thermal_ramp u_ramp
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .die_temp_i(die_temp_i),
    .begin_i(s_reg.heat_begin),
    .end_i(s_reg.heat_end),
    .cap_o(ramp_cap),
    .active_o(ramp_active)
  );

  // next state of the whole block
  always_comb
  begin
    s_next = s_reg;
    s_next.rd_valid = 1'b0;
    s_next.phase_prev = phase_lvl;

    if (wr_phase)
    begin
      s_next.phase_en = wr_data_i[`PHASE_W-1:0] & `PHASE_EN_MASK;
    end

    if (wr_loop)
    begin
      s_next.loop_en = wr_data_i[`LOOP_W-1:0];
    end

    if (wr_begin)
    begin
      s_next.heat_begin = wr_data_i;
    end

    if (wr_end)
    begin
      s_next.heat_end = wr_data_i;
    end

    // readback; an unknown command code answers zero
    if (rd_stb_i)
    begin
      s_next.rd_valid = 1'b1;
      s_next.rd_data = '0;
      if (cmd_hit(cmd_code_i, `CMD_PHASE_EN))
      begin
        s_next.rd_data[`PHASE_W-1:0] = s_reg.phase_en;
      end
      else if (cmd_hit(cmd_code_i, `CMD_LOOP_EN))
      begin
        s_next.rd_data[`LOOP_W-1:0] = s_reg.loop_en;
      end
      else if (cmd_hit(cmd_code_i, `CMD_HEAT_BEGIN))
      begin
        s_next.rd_data = s_reg.heat_begin;
      end
      else if (cmd_hit(cmd_code_i, `CMD_HEAT_END))
      begin
        s_next.rd_data = s_reg.heat_end;
      end
    end

    // pending phase events: the acknowledge clears them, but an entry seen
    // in the same cycle is ORed in after, so the set wins over the clear
    // detection failure latched
    if (alert_ack_i)
    begin
      s_next.pending = '0;
    end
    s_next.pending = s_next.pending | phase_rise;

    s_next.prohibit = bat_missing_i || bat_short_i;

    // latched events are gated by their enables at the output rather than
    // at capture, so enabling a bit later still reports an earlier entry
    // loop events are plain levels: they alert only while present
    // safety limit level
    s_next.alert = |(s_reg.pending & s_reg.phase_en) ||
                   |(loop_lvl & s_reg.loop_en);

    s_next.cap = ramp_cap;
    s_next.throttling = ramp_active;
  end

  // state register; enables clear and temperatures take their defaults
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_reg <= '0;
      s_reg.phase_en <= `PHASE_EN_RESET;
      s_reg.loop_en <= `LOOP_EN_RESET;
      s_reg.heat_begin <= `HEAT_BEGIN_RESET;
      s_reg.heat_end <= `HEAT_END_RESET;
      s_reg.cap <= `CAP_FULL;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register; the alert pin is open
  // drain, so its data is always low and only the enable moves
  assign rd_data_o = s_reg.rd_data;
  assign rd_valid_o = s_reg.rd_valid;
  assign alert_o = 1'b0;
  assign alert_oe_o = s_reg.alert;
  assign phase_pending_o = s_reg.pending;
  assign charge_prohibit_o = s_reg.prohibit;
  assign charge_cap_o = s_reg.cap;
  assign throttling_o = s_reg.throttling;
endmodule
`default_nettype wire

// File: pkg/charger_alert_consts.svh
// command codes, field positions, reset values and counts for the charger alert logic
`ifndef CHARGER_ALERT_CONSTS_SVH
`define CHARGER_ALERT_CONSTS_SVH

// widths of the register port and of the fields
`define CMD_W 8
`define DATA_W 16
`define PHASE_W 13
`define LOOP_W 6
`define CAP_W 5

// command codes of the registers
`define CMD_PHASE_EN 8'h0E
`define CMD_LOOP_EN 8'h0F
`define CMD_HEAT_BEGIN 8'h10
`define CMD_HEAT_END 8'h11

// reset values (begin 120 C, end 125 C in die temperature units)
`define PHASE_EN_RESET 13'h0000
`define LOOP_EN_RESET 6'h00
`define HEAT_BEGIN_RESET 16'h45E9
`define HEAT_END_RESET 16'h46D2

// implemented bits of the phase enable register; the rest read zero
`define PHASE_EN_MASK 13'h1F43

// phase enable bit positions
`define BIT_DETECT_FAIL 12
`define BIT_DETECTING 11
`define BIT_EQUALIZE 10
`define BIT_ABSORB 9
`define BIT_SUSPENDED 8
`define BIT_MAIN_PHASE 6
`define BIT_BAT_MISSING 1
`define BIT_BAT_SHORT 0

// loop enable bit positions
`define BIT_ILIM 5
`define BIT_THERMAL 4
`define BIT_UVCL 3
`define BIT_IIN_LIMIT 2
`define BIT_CC 1
`define BIT_CV 0

// charge-current cap scale and ramp divider sizing
`define CAP_FULL 5'h1F
`define CAP_ZERO 5'h00
`define RAMP_DIFF_W 17
`define RAMP_NUM_W 22
`define RAMP_STEP_W 3
`define RAMP_TOP_STEP 3'h4
`define RAMP_LAST_STEP 3'h0

`endif

// File: pkg/charger_alert_pkg.sv
// types shared by the charger alert logic and its thermal ramp
package charger_alert_pkg;
`include "charger_alert_consts.svh"

  // ramp divider sequence
  typedef enum logic {RAMP_IDLE, RAMP_DIVIDE} ramp_phase_type;

  // whole state of the thermal ramp
  typedef struct packed {
    ramp_phase_type phase;
    logic [`RAMP_STEP_W-1:0] step;
    logic [`RAMP_NUM_W-1:0] rem;
    logic [`RAMP_NUM_W-1:0] den;
    logic [`CAP_W-1:0] quot;
    logic [`CAP_W-1:0] cap;
    logic active;
  } ramp_state_type;

  // whole state of the alert block
  typedef struct packed {
    logic [`PHASE_W-1:0] phase_en;
    logic [`LOOP_W-1:0] loop_en;
    logic [`DATA_W-1:0] heat_begin;
    logic [`DATA_W-1:0] heat_end;
    logic [`PHASE_W-1:0] phase_prev;
    logic [`PHASE_W-1:0] pending;
    logic [`DATA_W-1:0] rd_data;
    logic rd_valid;
    logic alert;
    logic prohibit;
    logic [`CAP_W-1:0] cap;
    logic throttling;
  } alert_state_type;

endpackage

// File: verilog/thermal_ramp.sv
// thermal throttle: caps the charge-current setpoint on a linear ramp
`timescale 1ns/100ps
`default_nettype none
`include "charger_alert_consts.svh"
module thermal_ramp
  import charger_alert_pkg::*;
(
  input wire logic clk_i,                         // system clock
  input wire logic rst_n_i,                       // async reset, active low
  input wire logic [`DATA_W-1:0] die_temp_i,      // signed die temperature
  input wire logic [`DATA_W-1:0] begin_i,         // signed ramp start
  input wire logic [`DATA_W-1:0] end_i,           // signed ramp end
  output logic [`CAP_W-1:0] cap_o,                // current setpoint cap
  output logic active_o                           // cap below full scale
);
  ramp_state_type s_reg;
  ramp_state_type s_next;
  logic [`RAMP_DIFF_W-1:0] diff;
  logic [`RAMP_DIFF_W-1:0] span;
  logic [`RAMP_NUM_W-1:0] diff_w;
  logic [`RAMP_NUM_W-1:0] trial;

  // sign-extended distances; span may be negative on a bad setting
  assign diff = {die_temp_i[`DATA_W-1], die_temp_i} - {begin_i[`DATA_W-1], begin_i};
  assign span = {end_i[`DATA_W-1], end_i} - {begin_i[`DATA_W-1], begin_i};
  assign diff_w = {{(`RAMP_NUM_W-`RAMP_DIFF_W){1'b0}}, diff};
  assign trial = s_reg.den << s_reg.step;

  // restoring division for five quotient bits: the quotient never passes
  // full scale, so five steps replace a wide combinational divider
  always_comb
  begin
    s_next = s_reg;
    case (s_reg.phase)
      RAMP_IDLE:
      begin
        if ($signed(die_temp_i) <= $signed(begin_i))
        begin
          s_next.cap = `CAP_FULL;
          s_next.active = 1'b0;
        end
        else if ($signed(die_temp_i) >= $signed(end_i) || $signed(span) <= 0)
        begin
          s_next.cap = `CAP_ZERO;
          s_next.active = 1'b1;
        end
        else
        begin
          s_next.rem = (diff_w << 5) - diff_w;
          s_next.den = {{(`RAMP_NUM_W-`RAMP_DIFF_W){1'b0}}, span};
          s_next.quot = `CAP_ZERO;
          s_next.step = `RAMP_TOP_STEP;
          s_next.phase = RAMP_DIVIDE;
        end
      end
      RAMP_DIVIDE:
      begin
        if (s_reg.rem >= trial)
        begin
          s_next.rem = s_reg.rem - trial;
          s_next.quot[s_reg.step] = 1'b1;
        end
        if (s_reg.step == `RAMP_LAST_STEP)
        begin
          s_next.cap = `CAP_FULL - s_next.quot;
          // a rise below one step leaves full scale, which is not a cut
          s_next.active = (s_next.quot != `CAP_ZERO);
          s_next.phase = RAMP_IDLE;
        end
        else
        begin
          s_next.step = s_reg.step - 1'b1;
        end
      end
      default:
      begin
        s_next.phase = RAMP_IDLE;
      end
    endcase
  end

  // state register; cap starts at full scale
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_reg <= '0;
      s_reg.cap <= `CAP_FULL;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign cap_o = s_reg.cap;
  assign active_o = s_reg.active;
endmodule
`default_nettype wire

// File: verif/charger_alert_monitor.sv
// checker for the charger alert enable logic, bound to its ports
`timescale 1ns/100ps
`default_nettype none
module charger_alert_monitor
(
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, low
  input wire logic [7:0] cmd_code_i, // code
  input wire logic wr_stb_i, // write
  input wire logic [15:0] wr_data_i, // data
  input wire logic rd_stb_i, // read
  input wire logic [15:0] rd_data_o, // read data
  input wire logic rd_valid_o, // read valid
  input wire logic absorb_i, // phase
  input wire logic bat_missing_i, // fault
  input wire logic bat_short_i, // fault
  input wire logic ilim_active_i, // loop
  input wire logic uvcl_active_i, // loop
  input wire logic iin_limit_active_i, // loop
  input wire logic cc_active_i, // loop
  input wire logic cv_active_i, // loop
  input wire logic [15:0] die_temp_i, // die
  input wire logic alert_o, // line data
  input wire logic alert_oe_o, // line enable
  input wire logic [12:0] phase_pending_o, // pending
  input wire logic charge_prohibit_o, // prohibit
  input wire logic [4:0] charge_cap_o, // cap
  input wire logic throttling_o // throttle
);
  logic [12:0] pen_reg;
  logic [5:0] len_reg;
  logic [3:0] quiet_reg;
  logic [5:0] loops;
  logic exp_alert;
  // shadow enables and a count of quiet cycles for the ramp
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pen_reg <= 13'h0000;
      len_reg <= 6'h00;
      quiet_reg <= 4'h0;
    end
    else
    begin
      if (wr_stb_i && cmd_code_i == 8'h0E)
        pen_reg <= wr_data_i[12:0] & 13'h1F43;
      if (wr_stb_i && cmd_code_i == 8'h0F)
        len_reg <= wr_data_i[5:0];
      if (wr_stb_i || !$stable(die_temp_i))
        quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hF)
        quiet_reg <= quiet_reg + 4'h1;
    end
  end
  // thermal bit left out: its timing runs through the ramp
  assign loops = {ilim_active_i, 1'b0, uvcl_active_i, iin_limit_active_i, cc_active_i, cv_active_i};
  assign exp_alert = (|(phase_pending_o & pen_reg)) || (|(loops & len_reg));
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_valid_pulse: assert property (rd_stb_i |=> rd_valid_o) else $error("no read valid");
  a_no_stray_valid: assert property (!rd_stb_i |=> !rd_valid_o) else $error("stray read valid");
  a_unknown_reads_zero: assert property (rd_stb_i && (cmd_code_i < 8'h0E || cmd_code_i > 8'h11)
    |=> rd_data_o == 16'h0000) else $error("unknown code read nonzero");
  a_loop_readback: assert property (wr_stb_i && cmd_code_i == 8'h0F ##1 rd_stb_i && !wr_stb_i && cmd_code_i == 8'h0F
    |=> rd_data_o == ($past(wr_data_i, 2) & 16'h003F)) else $error("loop enable readback");
  a_read_data_holds: assert property (!rd_stb_i |=> $stable(rd_data_o)) else $error("read data moved");
  a_absorb_latch: assert property ($rose(absorb_i) |=> phase_pending_o[9]) else $error("absorb not latched");
  a_short_latch: assert property ($rose(bat_short_i) |=> phase_pending_o[0]) else $error("short not latched");
  a_prohibit_follows: assert property (1'b1 |=> charge_prohibit_o == $past(bat_missing_i || bat_short_i))
    else $error("prohibit wrong");
  a_alert_gating: assert property (!len_reg[4] |=> alert_oe_o == $past(exp_alert)) else $error("alert gating");
  a_throttle_cut: assert property (throttling_o == (charge_cap_o != 5'h1F)) else $error("throttle flag");
  a_cap_settles: assert property (quiet_reg > 4'hB |-> $stable(charge_cap_o)) else $error("cap unsettled");
  a_line_data_low: assert property (!alert_o) else $error("alert data high");
endmodule
bind charger_alert_enable_logic charger_alert_monitor u_charger_alert_monitor (.*);
`default_nettype wire

// File: verif/host_alert_model.sv
// host side: answers a low alert line slowly, or at once on a kick
`timescale 1ns/100ps
`default_nettype none
module host_alert_model #(parameter int DLY = 6)
(
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, low
  input wire logic alert_line_n_i, // pulled-up alert wire
  input wire logic kick_i, // answer next cycle
  output logic ack_o // alert response pulse
);
  logic [3:0] wait_reg;
  // a slow host waits DLY low cycles before it answers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_o <= 1'b0;
      wait_reg <= 4'h0;
    end
    else
    begin
      ack_o <= kick_i || (!alert_line_n_i && wait_reg == 4'(DLY - 1));
      wait_reg <= (alert_line_n_i || wait_reg == 4'(DLY - 1)) ? 4'h0 : wait_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: verif/charger_alert_enable_logic_bench.sv
// self-checking bench for the charger alert enable logic
`timescale 1ns/100ps
`default_nettype none
module charger_alert_enable_logic_bench;
  typedef struct packed {logic [7:0] ph; logic [4:0] lp; logic [12:0] pen; logic [5:0] len;
    logic [12:0] pend; logic al;} row_type;
  typedef struct packed {logic [15:0] lo; logic [15:0] hi; logic [15:0] die; logic [4:0] cap;
    logic thr;} heat_type;
  localparam row_type ROWS [15] = '{
    '{8'h80, 5'h00, 13'h1000, 6'h00, 13'h1000, 1'b1},
    '{8'h40, 5'h00, 13'h0800, 6'h00, 13'h0800, 1'b1},
    '{8'h20, 5'h00, 13'h0400, 6'h00, 13'h0400, 1'b1},
    '{8'h10, 5'h00, 13'h0200, 6'h00, 13'h0200, 1'b1},
    '{8'h08, 5'h00, 13'h0100, 6'h00, 13'h0100, 1'b1},
    '{8'h04, 5'h00, 13'h0040, 6'h00, 13'h0040, 1'b1},
    '{8'h02, 5'h00, 13'h0002, 6'h00, 13'h0002, 1'b1},
    '{8'h01, 5'h00, 13'h0001, 6'h00, 13'h0001, 1'b1},
    '{8'h10, 5'h00, 13'h1D43, 6'h00, 13'h0200, 1'b0},
    '{8'h00, 5'h10, 13'h0000, 6'h20, 13'h0000, 1'b1},
    '{8'h00, 5'h08, 13'h0000, 6'h08, 13'h0000, 1'b1},
    '{8'h00, 5'h04, 13'h0000, 6'h04, 13'h0000, 1'b1},
    '{8'h00, 5'h02, 13'h0000, 6'h02, 13'h0000, 1'b1},
    '{8'h00, 5'h01, 13'h0000, 6'h01, 13'h0000, 1'b1},
    '{8'h00, 5'h1F, 13'h0000, 6'h10, 13'h0000, 1'b0}};
  localparam heat_type HEATS [8] = '{
    '{16'h0064, 16'h0083, 16'h0064, 5'h1F, 1'b0}, '{16'h0064, 16'h0083, 16'h006E, 5'h15, 1'b1},
    '{16'h0064, 16'h0083, 16'h0083, 5'h00, 1'b1}, '{16'h0064, 16'h0083, 16'h00C8, 5'h00, 1'b1},
    '{16'h0064, 16'h0083, 16'h0032, 5'h1F, 1'b0}, '{16'hFFF6, 16'h0015, 16'hFFEC, 5'h1F, 1'b0},
    '{16'hFFF6, 16'h0015, 16'h0000, 5'h15, 1'b1}, '{16'h0083, 16'h0064, 16'h0090, 5'h00, 1'b1}};
  localparam logic [7:0] CMDS [5] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12};
  localparam logic [15:0] RST_VALS [5] = '{16'h0000, 16'h0000, 16'h45E9, 16'h46D2, 16'h0000};
  localparam logic [15:0] ALL_VALS [5] = '{16'h1F43, 16'h003F, 16'hFFFF, 16'hFFFF, 16'h0000};
  logic clk_i, rst_n_i, wr_stb_i, rd_stb_i, kick, ack, rd_valid_o, alert_o, alert_oe_o, alert_n;
  logic charge_prohibit_o, throttling_o;
  logic [7:0] cmd_code_i, ph;
  logic [4:0] lp, charge_cap_o;
  logic [15:0] wr_data_i, die_temp_i, rd_data_o;
  logic [12:0] phase_pending_o;
  int checked = 0;
  int miscompares = 0;
  int cycles = 0;
  // open-drain alert wire with its pull-up
  assign alert_n = alert_oe_o ? alert_o : 1'b1;
  charger_alert_enable_logic u_charger_alert_enable_logic (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_code_i(cmd_code_i), .wr_stb_i(wr_stb_i), .wr_data_i(wr_data_i), .rd_stb_i(rd_stb_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .detect_failed_i(ph[7]), .detecting_i(ph[6]),
    .equalize_i(ph[5]), .absorb_i(ph[4]), .suspended_i(ph[3]), .main_phase_i(ph[2]),
    .bat_missing_i(ph[1]), .bat_short_i(ph[0]), .ilim_active_i(lp[4]), .uvcl_active_i(lp[3]),
    .iin_limit_active_i(lp[2]), .cc_active_i(lp[1]), .cv_active_i(lp[0]), .alert_ack_i(ack),
    .die_temp_i(die_temp_i), .alert_o(alert_o), .alert_oe_o(alert_oe_o), .phase_pending_o(phase_pending_o),
    .charge_prohibit_o(charge_prohibit_o), .charge_cap_o(charge_cap_o), .throttling_o(throttling_o));
  host_alert_model u_host_alert_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .alert_line_n_i(alert_n),
    .kick_i(kick), .ack_o(ack));
  // free-running 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    @(negedge clk_i);
    cmd_code_i = cmd;
    wr_data_i = data;
    wr_stb_i = 1'b1;
    @(negedge clk_i);
    wr_stb_i = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] cmd, input logic [15:0] exp);
    @(negedge clk_i);
    cmd_code_i = cmd;
    rd_stb_i = 1'b1;
    @(negedge clk_i);
    rd_stb_i = 1'b0;
    chk("read valid", {15'h0000, rd_valid_o}, 16'h0001);
    chk("read data", rd_data_o, exp);
  endtask
  // reset, table of events, then registers, ordering and thermal ramp
  initial
  begin
    {rst_n_i, wr_stb_i, rd_stb_i, kick, ph, lp} = '0;
    {cmd_code_i, wr_data_i, die_temp_i} = '0;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk("cap", {11'h000, charge_cap_o}, 16'h001F);
    for (int i = 0; i < 5; i++)
      rdc(CMDS[i], RST_VALS[i]);
    foreach (ROWS[i])
    begin
      wr(8'h0E, {3'h0, ROWS[i].pen});
      wr(8'h0F, {10'h000, ROWS[i].len});
      ph = ROWS[i].ph;
      lp = ROWS[i].lp;
      repeat (3) @(negedge clk_i);
      chk("pending", {3'h0, phase_pending_o}, {3'h0, ROWS[i].pend});
      chk("alert line", {15'h0000, alert_n}, {15'h0000, !ROWS[i].al});
      chk("prohibit", {15'h0000, charge_prohibit_o}, {15'h0000, |ROWS[i].ph[1:0]});
      ph = 8'h00;
      lp = 5'h00;
      kick = 1'b1;
      @(negedge clk_i);
      kick = 1'b0;
      repeat (3) @(negedge clk_i);
      chk("cleared", {2'h0, phase_pending_o, alert_n}, 16'h0001);
    end
    // acknowledge and a new entry land on the same edge: set wins
    wr(8'h0E, 16'h0200);
    kick = 1'b1;
    @(negedge clk_i);
    kick = 1'b0;
    ph[4] = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("set wins", {3'h0, phase_pending_o}, 16'h0200);
    for (int i = 0; i < 5; i++)
      wr(CMDS[i], 16'hFFFF);
    for (int i = 0; i < 5; i++)
      rdc(CMDS[i], ALL_VALS[i]);
    // write and read together: the read returns the old value, and a
    // read right behind it returns the new one
    @(negedge clk_i);
    cmd_code_i = 8'h0F;
    wr_data_i = 16'h0000;
    wr_stb_i = 1'b1;
    rd_stb_i = 1'b1;
    @(negedge clk_i);
    wr_stb_i = 1'b0;
    chk("old read", rd_data_o, 16'h003F);
    @(negedge clk_i);
    rd_stb_i = 1'b0;
    chk("new read", rd_data_o, 16'h0000);
    rdc(8'h0F, 16'h0000);
    foreach (HEATS[i])
    begin
      wr(8'h10, HEATS[i].lo);
      wr(8'h11, HEATS[i].hi);
      die_temp_i = HEATS[i].die;
      repeat (12) @(negedge clk_i);
      chk("cap", {11'h000, charge_cap_o}, {11'h000, HEATS[i].cap});
      chk("throttling", {15'h0000, throttling_o}, {15'h0000, HEATS[i].thr});
    end
    wr(8'h0F, 16'h0010);
    repeat (10) @(negedge clk_i);
    chk("thermal alert", {15'h0000, alert_n}, 16'h0000);
    wr(8'h0F, 16'h0000);
    repeat (3) @(negedge clk_i);
    chk("thermal off", {15'h0000, alert_n}, 16'h0001);
    stop_test();
  end
endmodule
`default_nettype wire
